//--- include/pcev_defines.svh
// Command codes, field positions and reset values of the event flags
`ifndef PCEV_DEFINES_SVH
`define PCEV_DEFINES_SVH

`define PCEV_CMD_POWER_RD 8'h02
`define PCEV_CMD_POWER_COR 8'h03
`define PCEV_CMD_DISC_RD 8'h04
`define PCEV_CMD_DISC_COR 8'h05
`define PCEV_CMD_FAULT_RD 8'h06
`define PCEV_CMD_FAULT_COR 8'h07
`define PCEV_CMD_INRUSH_RD 8'h08
`define PCEV_CMD_INRUSH_COR 8'h09

`define PCEV_HI_LSB 4
`define PCEV_LO_LSB 0

`define PCEV_FLAGS_RST 8'h00
`define PCEV_READ_RST 8'h00
`define PCEV_SUMMARY_RST 7'h00

`define PCEV_SUM_PE 0
`define PCEV_SUM_PG 1
`define PCEV_SUM_DIS 2
`define PCEV_SUM_DET 3
`define PCEV_SUM_CLS 4
`define PCEV_SUM_OVL 5
`define PCEV_SUM_INRUSH_START_FAULT 6

`endif

//--- include/pcev_pkg.sv
// Types shared by the channel event flag block
package pcev_pkg;

    typedef logic [7:0] pcev_flags_t;
    typedef logic [3:0] pcev_chan_t;
    typedef logic [1:0] pcev_pair_t;

    // Event kinds that may wait for both channels of a four-pair port
    typedef enum logic [1:0] {
        PCEV_JOIN_PE = 2'b00,
        PCEV_JOIN_PG = 2'b01,
        PCEV_JOIN_DET = 2'b10,
        PCEV_JOIN_CLS = 2'b11
    } pcev_join_t;

endpackage

//--- hw/pcev_event_regs.sv
// Per-channel event flag registers with plain and clear-on-read access
//
// What this block does
// (R1) Power flags read at 02h unchanged, 03h returns same then clears all.
// (R2) Detection flags read at 04h plain, 05h same data then cleared.
// (R3) Fault flags read at 06h plain, 07h same data then cleared.
// (R4) Inrush/limit flags read at 08h plain, 09h same data then cleared.
// (R5) Clear-on-read of the register holding interrupt active releases it.
// (R6) Any set flag feeds its summary bit; flags active high per channel.
// (R7) Power bits 7-4 power-good change, 3-0 power-enable change; reset 0.
// (R8) Single-signature four-pair power bits set both only after both change.
// (R9) Bits 7-4 mark class cycle done, or class change in change mode.
// (R10) Bits 3-0 mark detect cycle done, or detect change in change mode.
// (R11) Detection, fault, inrush bits of a channel clear when it turns off.
// (R12) Four-pair without pending power-on sets both detect bits together.
// (R13) Single-signature four-pair sets class bit only for classified pair.
// (R14) Dual-signature without pending power-on sets both class bits together.
// (R15) Dual-signature with pending power-on sets bits per channel.
// (R16) Fault bits 7-4 disconnect, 3-0 overload timeout; reset 0.
// (R17) Single-signature disconnect sets both bits; others per channel.
// (R18) Host may re-power a faulted dual-signature channel if still valid; this block has no re-power logic.
// (R19) Overload flag still set when overload cutoff is disabled.
// (R20) Fault clear-on-read resets overload timers, not limit timers.
// (R21) Inrush bits 7-4 mark current held at limit beyond limit time.
// (R22) Inrush bits 3-0 mark start timeout or turn-on class/detect error.
// (R23) Interrupt only when mask bit and global enable set; flags ignore mask.
// (R24) A set in the cycle of a clear-on-read wins and survives.
// (R25) Flags held zero in reset, set only by event pulses after.
`timescale 1ns/100ps
`include "pcev_defines.svh"

module pcev_event_regs (
    input logic core_clk,
    input logic reset,
    input logic cmdStrobe,
    input logic [7:0] cmdCode,
    input logic [3:0] powerGoodChange,
    input logic [3:0] powerEnableChange,
    input logic [3:0] classDone,
    input logic [3:0] classChanged,
    input logic [3:0] detectDone,
    input logic [3:0] detectChanged,
    input logic [3:0] disconnectEvent,
    input logic [3:0] overloadTimeout,
    input logic [3:0] limitTimeout,
    input logic [3:0] inrushStartFault,
    input logic [3:0] channelOff,
    input logic [1:0] fourPairPort,
    input logic [1:0] singleSignature,
    input logic [1:0] powerOnPending,
    input logic class_change_mode,
    input logic detect_change_mode,
    input logic global_interrupt_enable,
    input logic [6:0] interruptMask,
    output logic [7:0] readData_q,
    output logic readValid_q,
    output logic [6:0] eventSummary_q,
    output logic interruptN_q,
    output logic [3:0] overloadTimerClear_q
);

    pcev_pkg::pcev_flags_t power_event_flags_q;
    pcev_pkg::pcev_flags_t discovery_event_flags_q;
    pcev_pkg::pcev_flags_t fault_event_flags_q;
    pcev_pkg::pcev_flags_t inrush_limit_event_flags_q;

    pcev_pkg::pcev_flags_t powerSet;
    pcev_pkg::pcev_flags_t discSet;
    pcev_pkg::pcev_flags_t faultSet;
    pcev_pkg::pcev_flags_t inrushSet;
    pcev_pkg::pcev_flags_t powerClr;
    pcev_pkg::pcev_flags_t discClr;
    pcev_pkg::pcev_flags_t faultClr;
    pcev_pkg::pcev_flags_t inrushClr;
    pcev_pkg::pcev_flags_t offMask;

    logic powerCor;
    logic discCor;
    logic faultCor;
    logic inrushCor;

    logic [3:0] joinEv [4];
    logic [1:0] joinEn [4];
    logic [3:0] joinSet [4];
    logic [3:0] hold_q [4];
    logic [3:0] hold_d [4];

    logic [3:0] disSet;
    logic [6:0] summary;
    logic intActive;

    // Clear-on-read strobes decoded from the command code
    assign powerCor = cmdStrobe && (cmdCode == `PCEV_CMD_POWER_COR); // [R1]
    assign discCor = cmdStrobe && (cmdCode == `PCEV_CMD_DISC_COR); // [R2]
    assign faultCor = cmdStrobe && (cmdCode == `PCEV_CMD_FAULT_COR); // [R3]
    assign inrushCor = cmdStrobe && (cmdCode == `PCEV_CMD_INRUSH_COR); // [R4]

    // Event inputs that may be joined across the two channels of a port
    assign joinEv[pcev_pkg::PCEV_JOIN_PE] = powerEnableChange;
    assign joinEv[pcev_pkg::PCEV_JOIN_PG] = powerGoodChange;
    assign joinEv[pcev_pkg::PCEV_JOIN_DET] =
        detect_change_mode ? detectChanged : detectDone; // [R10]
    assign joinEv[pcev_pkg::PCEV_JOIN_CLS] =
        class_change_mode ? classChanged : classDone; // [R9]

    // Power bits wait for both channels on single-signature loads
    assign joinEn[pcev_pkg::PCEV_JOIN_PE] =
        fourPairPort & singleSignature; // [R8]
    assign joinEn[pcev_pkg::PCEV_JOIN_PG] =
        fourPairPort & singleSignature; // [R8]
    // Pending power-on means staggered turn-on, so no joining
    assign joinEn[pcev_pkg::PCEV_JOIN_DET] =
        fourPairPort & ~powerOnPending; // [R12] [R15]
    // Single-signature class only flags the classified pair
    assign joinEn[pcev_pkg::PCEV_JOIN_CLS] =
        fourPairPort & ~singleSignature & ~powerOnPending; // [R13] [R14]

    genvar k;
    genvar p;
    generate
        for (k = 0; k < 4; k++) begin : gKind
            for (p = 0; p < 2; p++) begin : gPair
                logic [1:0] held;
                assign held = hold_q[k][2*p +: 2] | joinEv[k][2*p +: 2];
                // Both bits released in one cycle, so one interrupt only
                assign joinSet[k][2*p +: 2] = joinEn[k][p] ?
                    {2{&held}} : joinEv[k][2*p +: 2]; // [R8] [R12] [R14]
                assign hold_d[k][2*p +: 2] = (joinEn[k][p] && !(&held)) ?
                    (held & ~channelOff[2*p +: 2]) : 2'b00;
            end
        end
        for (p = 0; p < 2; p++) begin : gDis
            assign disSet[2*p +: 2] = (fourPairPort[p] && singleSignature[p]) ?
                {2{|disconnectEvent[2*p +: 2]}} :
                disconnectEvent[2*p +: 2]; // [R17]
        end
    endgenerate

    always_ff @(posedge core_clk) begin
        for (int i = 0; i < 4; i++) begin
            if (reset) begin
                hold_q[i] <= 4'h0;
            end else begin
                hold_q[i] <= hold_d[i];
            end
        end
    end

    assign powerSet = {joinSet[pcev_pkg::PCEV_JOIN_PG],
                       joinSet[pcev_pkg::PCEV_JOIN_PE]}; // [R7]
    assign discSet = {joinSet[pcev_pkg::PCEV_JOIN_CLS],
                      joinSet[pcev_pkg::PCEV_JOIN_DET]};
    // Overload flag is set whether or not cutoff is enabled
    assign faultSet = {disSet, overloadTimeout}; // [R16] [R19]
    assign inrushSet = {limitTimeout, inrushStartFault}; // [R21] [R22]

    assign offMask = {channelOff, channelOff}; // [R11]
    assign powerClr = powerCor ? 8'hFF : 8'h00;
    assign discClr = discCor ? 8'hFF : offMask; // [R11]
    assign faultClr = faultCor ? 8'hFF : offMask; // [R11]
    assign inrushClr = inrushCor ? 8'hFF : offMask; // [R11]

    // Set beats clear so an event during the read is seen next time
    always_ff @(posedge core_clk) begin
        if (reset) begin
            power_event_flags_q <= `PCEV_FLAGS_RST; // [R25]
        end else begin
            power_event_flags_q <=
                (power_event_flags_q & ~powerClr) | powerSet; // [R1] [R24]
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            discovery_event_flags_q <= `PCEV_FLAGS_RST; // [R25]
        end else begin
            discovery_event_flags_q <=
                (discovery_event_flags_q & ~discClr) | discSet; // [R2] [R24]
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            fault_event_flags_q <= `PCEV_FLAGS_RST; // [R25]
        end else begin
            fault_event_flags_q <=
                (fault_event_flags_q & ~faultClr) | faultSet; // [R3] [R24]
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            inrush_limit_event_flags_q <= `PCEV_FLAGS_RST; // [R25]
        end else begin
            inrush_limit_event_flags_q <=
                (inrush_limit_event_flags_q & ~inrushClr) | inrushSet; // [R4]
        end
    end

    // Read answer: the value before any clear takes effect
    always_ff @(posedge core_clk) begin
        if (reset) begin
            readData_q <= `PCEV_READ_RST;
            readValid_q <= 1'b0;
        end else begin
            readValid_q <= 1'b0;
            readData_q <= `PCEV_READ_RST;
            if (cmdStrobe) begin
                case (cmdCode)
                    `PCEV_CMD_POWER_RD, `PCEV_CMD_POWER_COR: begin
                        readData_q <= power_event_flags_q; // [R1]
                        readValid_q <= 1'b1;
                    end
                    `PCEV_CMD_DISC_RD, `PCEV_CMD_DISC_COR: begin
                        readData_q <= discovery_event_flags_q; // [R2]
                        readValid_q <= 1'b1;
                    end
                    `PCEV_CMD_FAULT_RD, `PCEV_CMD_FAULT_COR: begin
                        readData_q <= fault_event_flags_q; // [R3]
                        readValid_q <= 1'b1;
                    end
                    `PCEV_CMD_INRUSH_RD, `PCEV_CMD_INRUSH_COR: begin
                        readData_q <= inrush_limit_event_flags_q; // [R4]
                        readValid_q <= 1'b1;
                    end
                    default: begin
                        readData_q <= `PCEV_READ_RST;
                        readValid_q <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Limit timers live elsewhere and are deliberately not touched here
    always_ff @(posedge core_clk) begin
        if (reset) begin
            overloadTimerClear_q <= 4'h0;
        end else if (faultCor) begin
            overloadTimerClear_q <= fault_event_flags_q[3:0]; // [R20]
        end else begin
            overloadTimerClear_q <= 4'h0;
        end
    end

    assign summary[`PCEV_SUM_PE] = |power_event_flags_q[3:0]; // [R6]
    assign summary[`PCEV_SUM_PG] = |power_event_flags_q[7:4]; // [R6]
    assign summary[`PCEV_SUM_DIS] = |fault_event_flags_q[7:4]; // [R6]
    assign summary[`PCEV_SUM_DET] = |discovery_event_flags_q[3:0]; // [R6]
    assign summary[`PCEV_SUM_CLS] = |discovery_event_flags_q[7:4]; // [R6]
    assign summary[`PCEV_SUM_OVL] = |fault_event_flags_q[3:0] ||
                                    |inrush_limit_event_flags_q[7:4]; // [R6]
    assign summary[`PCEV_SUM_INRUSH_START_FAULT] =
        |inrush_limit_event_flags_q[3:0]; // [R6]

    // Mask gates only the pin; flags keep recording
    assign intActive = global_interrupt_enable &&
                       |(summary & interruptMask); // [R23]

    // Pin follows the flags, so clearing them releases it
    always_ff @(posedge core_clk) begin
        if (reset) begin
            eventSummary_q <= `PCEV_SUMMARY_RST;
            interruptN_q <= 1'b1;
        end else begin
            eventSummary_q <= summary; // [R6]
            interruptN_q <= !intActive; // [R5] [R23]
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    sequence powerCorNoSet;
        powerCor && (powerSet == 8'h00);
    endsequence

    sequence onlyPowerHoldsInt;
        !interruptN_q && (summary[6:2] & interruptMask[6:2]) == 5'h00;
    endsequence

    AST_POWER_COR_CLEARS: assert property ( // [R1]
        powerCorNoSet |=> power_event_flags_q == 8'h00)
        else $error("power clear-on-read left bits set");

    AST_PLAIN_READ_KEEPS: assert property ( // [R1]
        cmdStrobe && cmdCode == `PCEV_CMD_POWER_RD && powerClr == 8'h00 |=>
        readValid_q && readData_q == $past(power_event_flags_q) &&
        power_event_flags_q == ($past(power_event_flags_q) | $past(powerSet)))
        else $error("plain power read changed or misreported flags");

    AST_DISC_COR_CLEARS: assert property ( // [R2]
        discCor && discSet == 8'h00 |=>
        discovery_event_flags_q == 8'h00 &&
        readData_q == $past(discovery_event_flags_q))
        else $error("detection clear-on-read wrong");

    AST_FAULT_COR_CLEARS: assert property ( // [R3]
        faultCor && faultSet == 8'h00 |=> fault_event_flags_q == 8'h00)
        else $error("fault clear-on-read left bits set");

    AST_INRUSH_COR_CLEARS: assert property ( // [R4]
        inrushCor && inrushSet == 8'h00 |=>
        inrush_limit_event_flags_q == 8'h00)
        else $error("inrush clear-on-read left bits set");

    AST_COR_RELEASES_INT: assert property ( // [R5]
        onlyPowerHoldsInt ##0 powerCorNoSet ##1
        ((summary[6:2] & interruptMask[6:2]) == 5'h00)
        |=> interruptN_q)
        else $error("interrupt not released after clear-on-read");

    AST_INT_NEEDS_ENABLE: assert property ( // [R23]
        !global_interrupt_enable |=> interruptN_q)
        else $error("interrupt asserted with global enable off");

    AST_SUMMARY_TRACKS: assert property ( // [R6]
        ##1 eventSummary_q[`PCEV_SUM_PG] == $past(|power_event_flags_q[7:4]))
        else $error("power-good summary does not follow flags");

    AST_SS_POWER_JOIN: assert property ( // [R8]
        fourPairPort[0] && singleSignature[0] && hold_q[1][1:0] == 2'b00 &&
        powerGoodChange[1:0] == 2'b01 && !powerCor |=>
        power_event_flags_q[5:4] == $past(power_event_flags_q[5:4]))
        else $error("single-signature power-good flagged one channel");

    AST_OFF_CLEARS_FAULT: assert property ( // [R11]
        channelOff[0] && !faultSet[0] && !faultSet[4] |=>
        !fault_event_flags_q[0] && !fault_event_flags_q[4])
        else $error("fault bits kept after channel off");

    AST_SET_BEATS_COR: assert property ( // [R24]
        faultCor && faultSet[0] |=> fault_event_flags_q[0])
        else $error("event lost during clear-on-read");

    AST_OVL_TIMER_CLEAR: assert property ( // [R20]
        faultCor |=> overloadTimerClear_q == $past(fault_event_flags_q[3:0]))
        else $error("overload timer clear mismatch");

    AST_RESET_ZERO: assert property ( // [R25]
        @(posedge core_clk) disable iff (1'b0)
        reset |=> power_event_flags_q == 8'h00 && interruptN_q)
        else $error("flags not zero after reset");

endmodule

//--- tb/pcev_host_model.sv
// Host side model that issues command reads to the event flag registers
`timescale 1ns/100ps
module pcev_host_model (
    input wire logic core_clk,
    input wire logic [7:0] readData_q,
    input wire logic readValid_q,
    output logic cmdStrobe,
    output logic [7:0] cmdCode
);
    logic [7:0] lastRead = 8'h00;

    initial begin
        cmdStrobe = 1'b0;
        cmdCode = 8'h00;
    end

    always @(posedge core_clk) begin
        if (readValid_q) begin
            lastRead <= readData_q;
        end
    end

    // Never re-powers a faulted channel; power-on lives outside
    // Two codes back to back; released code lines show the inverse
    task automatic burst(input logic [7:0] a, input logic [7:0] b);
        @(posedge core_clk);
        cmdStrobe <= 1'b1;
        cmdCode <= a;
        @(posedge core_clk);
        cmdCode <= b;
        @(posedge core_clk);
        cmdStrobe <= 1'b0;
        cmdCode <= ~b;
    endtask
endmodule

//--- tb/test_pse_channel_event_registers.sv
// Random self-checking bench with a cycle model of the event flags
`timescale 1ns/100ps
module test_pse_channel_event_registers;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic cmdStrobe;
    logic [7:0] cmdCode;
    logic [3:0] powerGoodChange = 4'h0, powerEnableChange = 4'h0;
    logic [3:0] classDone = 4'h0, classChanged = 4'h0;
    logic [3:0] detectDone = 4'h0, detectChanged = 4'h0;
    logic [3:0] disconnectEvent = 4'h0, overloadTimeout = 4'h0;
    logic [3:0] limitTimeout = 4'h0, inrushStartFault = 4'h0;
    logic [3:0] channelOff = 4'h0;
    logic [1:0] fourPairPort = 2'h0, singleSignature = 2'h0;
    logic [1:0] powerOnPending = 2'h0;
    logic class_change_mode = 1'b0, detect_change_mode = 1'b0;
    logic global_interrupt_enable = 1'b0;
    logic [6:0] interruptMask = 7'h00;
    logic [7:0] readData_q, eData;
    logic readValid_q, interruptN_q, eValid, eIntN;
    logic [6:0] eventSummary_q, eSum;
    logic [3:0] overloadTimerClear_q, eClr, hPe, hPg, hDet, hCls, dis;
    logic [7:0] mf [4];
    logic [7:0] st [4];
    logic hit, cor;
    int idx;
    int errors = 0;
    int totalChecks = 0;
    int cycles = 0;
    logic [7:0] eLast = 8'h00;
    wire [1:0] joinPw = fourPairPort & singleSignature;
    wire [1:0] joinDet = fourPairPort & ~powerOnPending;
    wire [1:0] joinCls = joinDet & ~singleSignature;
    wire [3:0] detSrc = detect_change_mode ? detectChanged : detectDone;
    wire [3:0] clsSrc = class_change_mode ? classChanged : classDone;

    always #5 core_clk = ~core_clk;

    pcev_host_model hostU (.core_clk(core_clk), .readData_q(readData_q),
        .readValid_q(readValid_q), .cmdStrobe(cmdStrobe), .cmdCode(cmdCode));

    pcev_event_regs dut_u (.core_clk(core_clk), .reset(reset),
        .cmdStrobe(cmdStrobe), .cmdCode(cmdCode),
        .powerGoodChange(powerGoodChange),
        .powerEnableChange(powerEnableChange), .classDone(classDone),
        .classChanged(classChanged), .detectDone(detectDone),
        .detectChanged(detectChanged), .disconnectEvent(disconnectEvent),
        .overloadTimeout(overloadTimeout), .limitTimeout(limitTimeout),
        .inrushStartFault(inrushStartFault), .channelOff(channelOff),
        .fourPairPort(fourPairPort), .singleSignature(singleSignature),
        .powerOnPending(powerOnPending),
        .class_change_mode(class_change_mode),
        .detect_change_mode(detect_change_mode),
        .global_interrupt_enable(global_interrupt_enable),
        .interruptMask(interruptMask), .readData_q(readData_q),
        .readValid_q(readValid_q), .eventSummary_q(eventSummary_q),
        .interruptN_q(interruptN_q),
        .overloadTimerClear_q(overloadTimerClear_q));

    function automatic logic [3:0] rp();
        return 4'($urandom & $urandom & $urandom);
    endfunction

    function automatic logic [7:0] rc();
        return 8'($urandom_range(11, 0));
    endfunction

    function automatic logic [3:0] ex(input logic [1:0] v);
        return {{2{v[1]}}, {2{v[0]}}};
    endfunction

    // Joined pair waits until both channels pulsed, then sets both
    function automatic logic [7:0] joinf(input logic [3:0] h, p, o,
        input logic [1:0] en);
        logic [3:0] a, nh, s;
        a = h | p;
        nh = 4'h0;
        s = p;
        for (int k = 0; k < 2; k++) begin
            if (en[k]) begin
                s[2*k+:2] = (a[2*k+:2] == 2'b11) ? 2'b11 : 2'b00;
                nh[2*k+:2] = (a[2*k+:2] == 2'b11) ? 2'b00 :
                    a[2*k+:2] & ~o[2*k+:2];
            end
        end
        return {nh, s};
    endfunction

    function automatic logic [6:0] sumf(input logic [7:0] f [4]);
        return {|f[3][3:0], (|f[2][3:0]) | (|f[3][7:4]), |f[1][7:4],
            |f[1][3:0], |f[2][7:4], |f[0][7:4], |f[0][3:0]};
    endfunction

    always @(posedge core_clk) begin
        powerGoodChange <= rp();
        powerEnableChange <= rp();
        classDone <= rp();
        classChanged <= rp();
        detectDone <= rp();
        detectChanged <= rp();
        disconnectEvent <= rp();
        overloadTimeout <= rp();
        limitTimeout <= rp();
        inrushStartFault <= rp();
        // Off also drops the held half of a pair join on that channel
        channelOff <= rp();
    end

    always @(posedge core_clk) begin
        // Host latches the answer one edge after it appears
        if (eValid) begin
            eLast = eData;
        end
        if (reset) begin
            mf = '{default: 8'h00};
            {hPe, hPg, hDet, hCls} = 16'h0000;
            {eData, eValid, eSum, eClr} = 20'h0_0000;
            eIntN = 1'b1;
        end else begin
            eSum = sumf(mf);
            eIntN = !(global_interrupt_enable && (|(eSum & interruptMask)));
            hit = cmdStrobe && cmdCode >= 8'h02 && cmdCode <= 8'h09;
            idx = hit ? (int'(cmdCode) - 2) / 2 : 0;
            cor = hit && cmdCode[0];
            eValid = hit;
            eData = hit ? mf[idx] : 8'h00;
            eClr = (cor && idx == 2) ? mf[2][3:0] : 4'h0;
            {hPe, st[0][3:0]} =
                joinf(hPe, powerEnableChange, channelOff, joinPw);
            {hPg, st[0][7:4]} =
                joinf(hPg, powerGoodChange, channelOff, joinPw);
            {hDet, st[1][3:0]} =
                joinf(hDet, detSrc, channelOff, joinDet);
            {hCls, st[1][7:4]} =
                joinf(hCls, clsSrc, channelOff, joinCls);
            dis = ex({|disconnectEvent[3:2], |disconnectEvent[1:0]} & joinPw);
            st[2] = {disconnectEvent | dis, overloadTimeout};
            st[3] = {limitTimeout, inrushStartFault};
            for (int i = 0; i < 4; i++) begin
                if (cor && idx == i) begin
                    mf[i] = 8'h00;
                end
                if (i > 0) begin
                    mf[i] = mf[i] & ~{channelOff, channelOff};
                end
                mf[i] = mf[i] | st[i];
            end
        end
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    always @(negedge core_clk) begin
        chk(readData_q, eData);
        chk({7'h00, readValid_q}, {7'h00, eValid});
        chk({1'b0, eventSummary_q}, {1'b0, eSum});
        chk({7'h00, interruptN_q}, {7'h00, eIntN});
        chk({4'h0, overloadTimerClear_q}, {4'h0, eClr});
        chk(hostU.lastRead, eLast);
    end

    task end_of_test;
        if (errors == 0 && totalChecks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 12000) begin
            errors++;
            end_of_test;
        end
    end

    initial begin
        void'($urandom(32'h5752));
        for (int c = 0; c < 16; c++) begin
            @(posedge core_clk);
            reset <= 1'b1;
            fourPairPort <= (c < 4) ? 2'h0 : 2'($urandom);
            singleSignature <= 2'($urandom);
            powerOnPending <= 2'($urandom);
            class_change_mode <= 1'($urandom);
            detect_change_mode <= 1'($urandom);
            global_interrupt_enable <= ($urandom_range(3, 0) != 0);
            interruptMask <= 7'($urandom);
            repeat (6) @(posedge core_clk);
            reset <= 1'b0;
            repeat (150) hostU.burst(rc(), rc());
        end
        end_of_test;
    end
endmodule
